// File: rtl/dma_desc_defs.svh
// Offsets, descriptor field positions and codes of the channel engine
`ifndef DMA_DESC_DEFS_SVH
`define DMA_DESC_DEFS_SVH

`define CHAN_COUNT 5
`define LAST_CHAN 3'd4
`define LAST_FETCH 3'd7

`define REG_PTR0 8'h00
`define REG_PTR1 8'h04
`define REG_ARM 8'h08
`define REG_REQ 8'h0c
`define REG_FLAG 8'h10
`define REG_STAT 8'h14
`define ARM_ABORT_BIT 7

`define DESC_SRC 63:48
`define DESC_DST 47:32
`define DESC_VARLEN 31:29
`define DESC_LEN 28:16
`define DESC_WORD 15
`define DESC_MODE 14:13
`define DESC_REPEAT 14
`define DESC_BLOCK 13
`define DESC_TRIGGER 12:8
`define DESC_SINC 7:6
`define DESC_DINC 5:4
`define DESC_IRQ 3
`define DESC_SEVEN 2
`define DESC_PRIO 1:0

`define VARLEN_PLUS1 3'b001
`define VARLEN_EXACT 3'b010
`define VARLEN_PLUS2 3'b011
`define VARLEN_PLUS3 3'b100
`define VARLEN_WORD_BITS 12:0
`define VARLEN_BYTE_BITS 7:0
`define VARLEN_SEVEN_BITS 6:0

`define TRIGGER_SW 5'h00
`define TRIGGER_PREV 5'h01
`define PRIO_LOW 2'b00
`define PRIO_GUAR 2'b01

`define STEP_NONE 2'b00
`define STEP_ONE 2'b01
`define STEP_TWO 2'b10
`define STEP_BACK 2'b11

`endif

// File: rtl/dma_pkg.sv
// Types shared by the descriptor engine
package dma_pkg;
    typedef logic [4:0] chan_mask_t;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_fetch = 3'b001,
        st_wait = 3'b011,
        st_arb = 3'b010,
        st_read = 3'b110,
        st_write = 3'b111,
        st_done = 3'b101
    } dma_state_t;

    typedef struct packed {
        dma_state_t state;
        logic ack;
        logic [31:0] rdat;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        chan_mask_t arm;
        chan_mask_t req;
        chan_mask_t flag;
        chan_mask_t prev;
        chan_mask_t irq;
        logic [2:0] chan;
        logic [2:0] idx;
        logic [63:0] desc;
        logic [15:0] src;
        logic [15:0] dst;
        logic [12:0] rem;
        logic first;
        logic lost;
        logic [15:0] data;
        logic [15:0] maddr;
        logic mrd;
        logic mwr;
        logic mword;
        logic [15:0] mwdata;
    } dma_regs_t;
endpackage : dma_pkg

// File: rtl/addr_step.sv
// Address stepping after one element
`timescale 1ns/10ps
`include "dma_desc_defs.svh"
module addr_step (
    input wire logic [15:0] i_addr, // Current address
    input wire logic [1:0] i_code, // Step code
    input wire logic i_word, // Element is 16 bits
    output logic [15:0] o_addr // Stepped address
);
    logic [15:0] size;

    always_comb begin
        size = i_word ? 16'h0002 : 16'h0001;
        case (i_code)
            `STEP_NONE: o_addr = i_addr;
            `STEP_ONE: o_addr = i_addr + size;
            `STEP_TWO: o_addr = i_addr + {size[14:0], 1'b0};
            `STEP_BACK: o_addr = i_addr - size;
            default: o_addr = i_addr;
        endcase
    end
endmodule : addr_step

// File: rtl/dma_channel_descriptor_decode.sv
// Five-channel descriptor fetch, decode and element mover
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "dma_desc_defs.svh"
module dma_channel_descriptor_decode (
    input wire logic i_clock, // System clock
    input wire logic i_sys_rst, // Asynchronous reset, high
    input wire logic i_wb_cyc, // Wishbone cycle
    input wire logic i_wb_stb, // Wishbone strobe
    input wire logic i_wb_we, // Wishbone write
    input wire logic [7:0] i_wb_adr, // Wishbone byte address
    input wire logic [3:0] i_wb_sel, // Wishbone byte lanes
    input wire logic [31:0] i_wb_dat, // Wishbone write data
    output logic [31:0] o_wb_dat, // Wishbone read data
    output logic o_wb_ack, // Wishbone acknowledge
    output logic [15:0] o_mem_addr, // Data memory address
    output logic o_mem_rd, // Memory read request
    output logic o_mem_wr, // Memory write request
    output logic o_mem_word, // 16-bit element
    output logic [15:0] o_mem_wdata, // Memory write data
    input wire logic [15:0] i_mem_rdata, // Memory read data
    input wire logic i_mem_ack, // Memory access done
    input wire logic i_cpu_req, // CPU wants the bus
    input wire logic [31:0] i_trigger, // Peripheral trigger pulses
    output dma_pkg::chan_mask_t o_done_irq // Completion interrupt pulses
);
    import dma_pkg::*;

    dma_regs_t s;
    dma_regs_t n;
    logic acc;
    logic wr;
    logic arm_wr;
    logic go;
    logic hit;
    logic fixed;
    logic [2:0] pick;
    logic [2:0] next_chan;
    logic [15:0] base;
    logic [63:0] fd;
    logic [12:0] vraw;
    logic [13:0] tot;
    logic [12:0] cap;
    logic [12:0] rem_next;
    logic [15:0] src_step;
    logic [15:0] dst_step;

    // Round robin so a repeated channel cannot starve the others
    function automatic logic [2:0] pick_next(input chan_mask_t arm,
                                             input logic [2:0] last);
        logic [3:0] c;
        pick_next = last;
        for (int k = `CHAN_COUNT; k >= 1; k--) begin
            c = {1'b0, last} + 4'(k);
            if (c >= 4'(`CHAN_COUNT)) begin
                c = c - 4'(`CHAN_COUNT);
            end
            if (arm[c[2:0]]) begin
                pick_next = c[2:0];
            end
        end
    endfunction : pick_next

    addr_step u_src_step (
        .i_addr(s.src),
        .i_code(s.desc[`DESC_SINC]),
        .i_word(s.desc[`DESC_WORD]),
        .o_addr(src_step)
    );

    addr_step u_dst_step (
        .i_addr(s.dst),
        .i_code(s.desc[`DESC_DINC]),
        .i_word(s.desc[`DESC_WORD]),
        .o_addr(dst_step)
    );

    always_comb begin
        acc = i_wb_cyc & i_wb_stb & ~s.ack;
        wr = acc & i_wb_we;
        arm_wr = wr && i_wb_adr == `REG_ARM && i_wb_sel[0];
        pick = pick_next(s.arm, s.chan);
        next_chan = (s.chan == `LAST_CHAN) ? 3'd0 : s.chan + 3'd1;
        // Channels 1-4 sit back to back behind the channel 1 pointer
        base = (pick == 3'd0) ? s.ptr0 :
            s.ptr1 + {10'h000, pick - 3'd1, 3'b000};
        fd = {s.desc[55:0], i_mem_rdata[7:0]};
        fixed = !(s.desc[`DESC_VARLEN] inside {`VARLEN_PLUS1, `VARLEN_EXACT,
            `VARLEN_PLUS2, `VARLEN_PLUS3});
        if (s.desc[`DESC_WORD]) begin
            vraw = s.data[`VARLEN_WORD_BITS];
        end else if (s.desc[`DESC_SEVEN]) begin
            vraw = {6'h00, s.data[`VARLEN_SEVEN_BITS]};
        end else begin
            vraw = {5'h00, s.data[`VARLEN_BYTE_BITS]};
        end
        case (s.desc[`DESC_VARLEN])
            `VARLEN_PLUS1: tot = {1'b0, vraw} + 14'h0001;
            `VARLEN_EXACT: tot = {1'b0, vraw};
            `VARLEN_PLUS2: tot = {1'b0, vraw} + 14'h0002;
            `VARLEN_PLUS3: tot = {1'b0, vraw} + 14'h0003;
            default: tot = {1'b0, s.desc[`DESC_LEN]};
        endcase
        cap = (tot > {1'b0, s.desc[`DESC_LEN]}) ? s.desc[`DESC_LEN] :
            tot[12:0];
        // The length element is already moved when the length is known
        if (s.first && !fixed) begin
            rem_next = (cap == 13'h0000) ? 13'h0000 : cap - 13'h0001;
        end else begin
            rem_next = s.rem - 13'h0001;
        end
        case (s.desc[`DESC_PRIO])
            `PRIO_LOW: go = !i_cpu_req;
            `PRIO_GUAR: go = !i_cpu_req || s.lost;
            default: go = 1'b1;
        endcase
        case (s.desc[`DESC_TRIGGER])
            `TRIGGER_SW: hit = s.req[s.chan];
            `TRIGGER_PREV: hit = s.req[s.chan] || s.prev[s.chan];
            default: hit = s.req[s.chan] || i_trigger[s.desc[`DESC_TRIGGER]];
        endcase
    end

    always_comb begin
        n = s;
        n.irq = '0;
        n.ack = acc;
        n.rdat = '0;
        // Clear before the engine so a completion in the same cycle wins
        if (wr && i_wb_adr == `REG_FLAG && i_wb_sel[0]) begin
            n.flag = s.flag & ~i_wb_dat[4:0];
        end
        case (s.state)
            st_idle: begin
                if (|s.arm) begin
                    n.chan = pick;
                    n.idx = 3'd0;
                    n.maddr = base;
                    n.mrd = 1'b1;
                    n.mword = 1'b0;
                    n.state = st_fetch;
                end
            end
            st_fetch: begin
                if (i_mem_ack) begin
                    n.desc = fd;
                    if (s.idx == `LAST_FETCH) begin
                        n.mrd = 1'b0;
                        n.src = fd[`DESC_SRC];
                        n.dst = fd[`DESC_DST];
                        n.first = 1'b1;
                        n.lost = 1'b0;
                        if (fd[`DESC_VARLEN] inside {`VARLEN_PLUS1,
                                `VARLEN_EXACT, `VARLEN_PLUS2, `VARLEN_PLUS3})
                        begin
                            n.rem = 13'h0001;
                        end else begin
                            n.rem = fd[`DESC_LEN];
                        end
                        n.state = st_wait;
                    end else begin
                        n.idx = s.idx + 3'd1;
                        n.maddr = s.maddr + 16'h0001;
                    end
                end
            end
            st_wait: begin
                if (hit) begin
                    n.req[s.chan] = 1'b0;
                    n.prev[s.chan] = 1'b0;
                    n.state = (s.rem == 13'h0000) ? st_done : st_arb;
                end
            end
            st_arb: begin
                if (go) begin
                    n.lost = 1'b0;
                    n.maddr = s.src;
                    n.mrd = 1'b1;
                    n.mword = s.desc[`DESC_WORD];
                    n.state = st_read;
                end else begin
                    n.lost = 1'b1;
                end
            end
            st_read: begin
                if (i_mem_ack) begin
                    n.mrd = 1'b0;
                    n.data = s.desc[`DESC_WORD] ? i_mem_rdata :
                        {8'h00, i_mem_rdata[7:0]};
                    n.mwdata = n.data;
                    n.maddr = s.dst;
                    n.mwr = 1'b1;
                    n.state = st_write;
                end
            end
            st_write: begin
                if (i_mem_ack) begin
                    n.mwr = 1'b0;
                    n.first = 1'b0;
                    n.src = src_step;
                    n.dst = dst_step;
                    n.rem = rem_next;
                    if (rem_next == 13'h0000) begin
                        n.state = st_done;
                    end else if (s.desc[`DESC_BLOCK]) begin
                        n.state = st_arb;
                    end else begin
                        n.state = st_wait;
                    end
                end
            end
            st_done: begin
                n.flag[s.chan] = 1'b1;
                n.irq[s.chan] = s.desc[`DESC_IRQ];
                if (!s.desc[`DESC_REPEAT]) begin
                    n.arm[s.chan] = 1'b0;
                end
                n.prev[next_chan] = 1'b1;
                n.state = st_idle;
            end
            default: begin
                n.state = st_idle;
            end
        endcase
        if (wr && i_wb_adr == `REG_PTR0) begin
            if (i_wb_sel[0]) n.ptr0[7:0] = i_wb_dat[7:0];
            if (i_wb_sel[1]) n.ptr0[15:8] = i_wb_dat[15:8];
        end
        if (wr && i_wb_adr == `REG_PTR1) begin
            if (i_wb_sel[0]) n.ptr1[7:0] = i_wb_dat[7:0];
            if (i_wb_sel[1]) n.ptr1[15:8] = i_wb_dat[15:8];
        end
        if (arm_wr) begin
            if (i_wb_dat[`ARM_ABORT_BIT]) begin
                n.arm = n.arm & ~i_wb_dat[4:0];
            end else begin
                n.arm = i_wb_dat[4:0];
            end
        end
        if (wr && i_wb_adr == `REG_REQ && i_wb_sel[0]) begin
            n.req = n.req | i_wb_dat[4:0];
        end
        // Disarm stops the channel at once; a half-done element is dropped
        if (s.state != st_idle && s.state != st_done && !n.arm[s.chan]) begin
            n.state = st_idle;
            n.mrd = 1'b0;
            n.mwr = 1'b0;
        end
        if (acc && !i_wb_we) begin
            case (i_wb_adr)
                `REG_PTR0: n.rdat = {16'h0000, s.ptr0};
                `REG_PTR1: n.rdat = {16'h0000, s.ptr1};
                `REG_ARM: n.rdat = {27'h0000000, s.arm};
                `REG_REQ: n.rdat = {27'h0000000, s.req};
                `REG_FLAG: n.rdat = {27'h0000000, s.flag};
                `REG_STAT: n.rdat = {11'h000, s.rem, 1'b0, s.chan,
                                     1'b0, s.state};
                default: n.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign o_wb_dat = s.rdat;
    assign o_wb_ack = s.ack;
    assign o_mem_addr = s.maddr;
    assign o_mem_rd = s.mrd;
    assign o_mem_wr = s.mwr;
    assign o_mem_word = s.mword;
    assign o_mem_wdata = s.mwdata;
    assign o_done_irq = s.irq;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    sequence s_first_grant;
        s.state == st_arb && s.first && go && s.arm[s.chan];
    endsequence

    sequence s_first_read_done;
        s.state == st_read && s.first && i_mem_ack && s.arm[s.chan];
    endsequence

    property p_src_first;
        s_first_grant |=> o_mem_rd && o_mem_addr == s.desc[`DESC_SRC];
    endproperty
    a_src_first: assert property (p_src_first)
        else $error("first read not at descriptor source");

    property p_dst_first;
        s_first_read_done ##1 o_mem_wr |-> o_mem_addr == s.desc[`DESC_DST];
    endproperty
    a_dst_first: assert property (p_dst_first)
        else $error("first write not at descriptor destination");

    property p_fixed_count;
        s.state == st_wait && $past(s.state) == st_fetch && fixed
            |-> s.rem == s.desc[`DESC_LEN];
    endproperty
    a_fixed_count: assert property (p_fixed_count)
        else $error("fixed count not taken from count field");

    property p_var_cap;
        s.state == st_write && i_mem_ack && s.first && !fixed
            && s.arm[s.chan] |=> s.rem == 13'h0000
            || {1'b0, s.rem} < {1'b0, s.desc[`DESC_LEN]};
    endproperty
    a_var_cap: assert property (p_var_cap)
        else $error("variable length exceeds count field");

    property p_width;
        s.state == st_read && o_mem_rd |-> o_mem_word == s.desc[`DESC_WORD];
    endproperty
    a_width: assert property (p_width)
        else $error("element width differs from descriptor");

    property p_low_prio;
        s.state == st_arb && s.desc[`DESC_PRIO] == `PRIO_LOW && i_cpu_req
            |=> !o_mem_rd;
    endproperty
    a_low_prio: assert property (p_low_prio)
        else $error("low priority channel took the bus from the CPU");

    property p_guar_prio;
        (s.state == st_arb && s.desc[`DESC_PRIO] == `PRIO_GUAR)[*2]
            |=> s.state != st_arb;
    endproperty
    a_guar_prio: assert property (p_guar_prio)
        else $error("guaranteed channel deferred twice in a row");

    property p_src_back;
        s.state == st_write && i_mem_ack && !s.desc[`DESC_WORD]
            && s.desc[`DESC_SINC] == `STEP_BACK && s.arm[s.chan]
            |=> s.src == $past(s.src) - 16'h0001;
    endproperty
    a_src_back: assert property (p_src_back)
        else $error("source did not step back one byte");

    property p_dst_two_words;
        s.state == st_write && i_mem_ack && s.desc[`DESC_WORD]
            && s.desc[`DESC_DINC] == `STEP_TWO && s.arm[s.chan]
            |=> s.dst == $past(s.dst) + 16'h0004;
    endproperty
    a_dst_two_words: assert property (p_dst_two_words)
        else $error("destination did not step two words");

    property p_irq_gate;
        |o_done_irq |-> $past(s.state) == st_done && $past(s.desc[`DESC_IRQ]);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("completion interrupt without enable");

    property p_flag_set;
        s.state == st_done |=> s.flag[$past(s.chan)];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("completion flag not set");

    property p_disarm;
        s.state == st_done && !s.desc[`DESC_REPEAT] && !arm_wr
            |=> !s.arm[$past(s.chan)];
    endproperty
    a_disarm: assert property (p_disarm)
        else $error("single or block channel still armed after completion");

    property p_fetch_base;
        s.state == st_idle && |s.arm |=> o_mem_rd && o_mem_addr == $past(base);
    endproperty
    a_fetch_base: assert property (p_fetch_base)
        else $error("descriptor fetched from wrong address");
endmodule : dma_channel_descriptor_decode

// File: verification/mem_model.sv
// Behavioural data memory on the engine's element port
`timescale 1ns/10ps
module mem_model (
    input wire logic i_clock, // System clock
    input wire logic i_slow, // Answer after three wait cycles
    input wire logic [15:0] i_addr, // Byte address
    input wire logic i_rd, // Read request
    input wire logic i_wr, // Write request
    input wire logic i_word, // 16-bit element
    input wire logic [15:0] i_wdata, // Write data
    output logic [15:0] o_rdata, // Read data
    output logic o_ack // One-cycle completion
);
    logic [7:0] m [0:65535];
    logic [15:0] q;
    logic [1:0] cnt;
    // Data is only valid with ack, so show garbage otherwise
    assign o_rdata = o_ack ? q : ~q;
    initial begin
        o_ack = 1'b0;
        q = 16'h0;
        cnt = 2'd0;
    end
    always @(posedge i_clock) begin
        o_ack <= 1'b0;
        if ((i_rd || i_wr) && !o_ack) begin
            if (cnt == (i_slow ? 2'd3 : 2'd0)) begin
                cnt <= 2'd0;
                o_ack <= 1'b1;
                q <= {i_word ? m[i_addr + 16'h1] : 8'h00, m[i_addr]};
                if (i_wr) begin
                    m[i_addr] <= i_wdata[7:0];
                    if (i_word) m[i_addr + 16'h1] <= i_wdata[15:8];
                end
            end else begin
                cnt <= cnt + 2'd1;
            end
        end
    end
endmodule : mem_model

// File: verification/dma_channel_descriptor_decode_test.sv
// Self-checking bench of the descriptor engine
`timescale 1ns/10ps
`include "dma_desc_defs.svh"
module dma_channel_descriptor_decode_test;
    import dma_pkg::*;
    logic i_clock, i_sys_rst, cyc, stb, we, ack, mrd, mwr, mword, mack;
    logic cpu, slow;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, evt, r;
    logic [15:0] maddr, mwdata, mrdata, seed;
    logic [2:0] codes [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd7};
    chan_mask_t irq, irq_seen;
    int n_mismatch, compares, n_wr, ch, l, n;

    dma_channel_descriptor_decode dma_channel_descriptor_decode_inst (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_mem_addr(maddr), .o_mem_rd(mrd), .o_mem_wr(mwr),
        .o_mem_word(mword), .o_mem_wdata(mwdata), .i_mem_rdata(mrdata),
        .i_mem_ack(mack), .i_cpu_req(cpu), .i_trigger(evt),
        .o_done_irq(irq));
    mem_model mem_model_inst (.i_clock(i_clock), .i_slow(slow),
        .i_addr(maddr), .i_rd(mrd), .i_wr(mwr), .i_word(mword),
        .i_wdata(mwdata), .o_rdata(mrdata), .o_ack(mack));

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (mwr && mack) n_wr++;
        irq_seen = irq_seen | irq;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic int expect_n(input logic [2:0] v, input int len,
                                    input int x);
        int t;
        case (v)
            3'b001: t = x + 1;
            3'b010: t = x;
            3'b011: t = x + 2;
            3'b100: t = x + 3;
            default: t = len;
        endcase
        return t > len ? len : t;
    endfunction : expect_n

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    // Classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge i_clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        @(posedge i_clock);
        while (ack !== 1'b1) @(posedge i_clock);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic wait_flag(input int c);
        n = 0;
        r = 32'h0;
        while (r[c] !== 1'b1 && n < 300) begin
            wb(1'b0, `REG_FLAG, 32'h0);
            n++;
        end
        chk(32'h1, 32'(r[c]));
        wb(1'b1, `REG_FLAG, 32'h1 << c);
    endtask : wait_flag
    task automatic setup(input int c, input logic [63:0] d);
        for (int k = 0; k < 8; k++)
            mem_model_inst.m[16'h0100 + 16'(k)] = d[63 - 8 * k -: 8];
        if (c == 0) wb(1'b1, `REG_PTR0, 32'h0100);
        else wb(1'b1, `REG_PTR1, 32'h0100 - 32'(8 * (c - 1)));
        n_wr = 0;
        irq_seen = '0;
        wb(1'b1, `REG_ARM, 32'h1 << c);
    endtask : setup
    task automatic pulse(input int k);
        @(posedge i_clock);
        evt <= 32'h1 << k;
        @(posedge i_clock);
        evt <= 32'h0;
    endtask : pulse
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    initial begin
        #200000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {cyc, stb, we, adr, sel, dat, cpu, evt, slow} = '0;
        {n_mismatch, compares, n_wr} = '0;
        irq_seen = '0;
        seed = 16'h005b;
        i_sys_rst = 1'b1;
        repeat (6) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        wb(1'b0, 8'hfc, 32'h0);
        chk(32'h0, r);
        wb(1'b1, `REG_PTR0, 32'h1234);
        wb(1'b0, `REG_PTR0, 32'h0);
        chk(32'h1234, r);
        $display("register test done");
        // Block moves over length codes 0 to 4 and 7; destinations in RAM only
        foreach (codes[i]) begin
            ch = i % 5;
            seed = lfsr(seed);
            slow <= seed[0];
            l = int'(seed[11:8]) % 12 + 1;
            for (int k = 0; k < 16; k++) begin
                seed = lfsr(seed);
                mem_model_inst.m[16'h1000 + 16'(k)] = seed[7:0];
            end
            mem_model_inst.m[16'h1000] = 8'(l);
            setup(ch, {16'h1000, 16'h2000, codes[i], 13'd12, 1'b0, 2'b01,
                       5'h00, 2'b01, 2'b01, 1'b1, 1'b0, 2'b10});
            wb(1'b1, `REG_REQ, 32'h1 << ch);
            wait_flag(ch);
            chk(expect_n(codes[i], 12, l), n_wr);
            for (int k = 0; k < n_wr; k++)
                chk(mem_model_inst.m[16'h1000 + 16'(k)],
                    mem_model_inst.m[16'h2000 + 16'(k)]);
            wb(1'b0, `REG_ARM, 32'h0);
            chk(32'h0, 32'(r[ch]));
            chk(32'h1, 32'(irq_seen[ch]));
            $display("length code %0d test done", codes[i]);
        end
        mem_model_inst.m[16'h1000] = 8'h83;
        // Guaranteed priority against a busy CPU: every other try wins
        setup(0, {16'h1000, 16'h2000, 3'b001, 13'd20, 1'b0, 2'b01, 5'h00,
                  2'b01, 2'b01, 1'b1, 1'b1, 2'b01});
        cpu <= 1'b1;
        wb(1'b1, `REG_REQ, 32'h1);
        wait_flag(0);
        cpu <= 1'b0;
        chk(32'd4, n_wr);
        $display("seven bit length test done");
        for (int k = 0; k < 20; k++) begin
            seed = lfsr(seed);
            mem_model_inst.m[16'h3000 + 16'(k)] = seed[7:0];
        end
        mem_model_inst.m[16'h3000] = 8'h05;
        mem_model_inst.m[16'h3001] = 8'he0;
        // Started only by channel 0 finishing, no software request
        setup(1, {16'h3000, 16'h4000, 3'b010, 13'd8, 1'b1, 2'b01, 5'h01,
                  2'b10, 2'b11, 1'b1, 1'b0, 2'b10});
        wait_flag(1);
        chk(32'd5, n_wr);
        for (int k = 0; k < 5; k++)
            chk({mem_model_inst.m[16'h3001 + 16'(4 * k)],
                 mem_model_inst.m[16'h3000 + 16'(4 * k)]},
                {mem_model_inst.m[16'h4001 - 16'(2 * k)],
                 mem_model_inst.m[16'h4000 - 16'(2 * k)]});
        $display("word step test done");
        // Single mode, low priority, peripheral trigger, no interrupt
        setup(0, {16'h1000, 16'h2100, 3'b000, 13'd2, 1'b0, 2'b00, 5'h05,
                  2'b11, 2'b01, 1'b0, 1'b0, 2'b00});
        cpu <= 1'b1;
        r = 32'h0;
        while (r[2:0] !== st_wait) wb(1'b0, `REG_STAT, 32'h0);
        pulse(5);
        repeat (20) @(posedge i_clock);
        chk(32'd0, n_wr);
        cpu <= 1'b0;
        repeat (20) @(posedge i_clock);
        chk(32'd1, n_wr);
        pulse(5);
        wait_flag(0);
        chk(32'd2, n_wr);
        chk(32'h0, 32'(irq_seen[0]));
        $display("single mode test done");
        // Repeated block at high priority against a busy CPU
        setup(2, {16'h1000, 16'h2200, 3'b111, 13'd3, 1'b1, 2'b11, 5'h00,
                  2'b01, 2'b10, 1'b1, 1'b0, 2'b10});
        cpu <= 1'b1;
        wb(1'b1, `REG_REQ, 32'h4);
        wait_flag(2);
        chk(32'd3, n_wr);
        wb(1'b0, `REG_ARM, 32'h0);
        chk(32'h1, 32'(r[2]));
        wb(1'b1, `REG_ARM, 32'h84);
        wb(1'b0, `REG_ARM, 32'h0);
        chk(32'h0, 32'(r[2]));
        cpu <= 1'b0;
        $display("repeated mode test done");
        print_verdict();
    end
endmodule : dma_channel_descriptor_decode_test
